// [verilog/paof_pkg.sv]
/*
  Shared constants for the port alternate-function override block:
  pin positions and the address-mask thresholds for port C.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package paof_pkg;
  // ----------------------------------------
  // port b pin positions
  // ----------------------------------------
  localparam int PB_SEL = 0;
  localparam int PB_SCK = 1;
  localparam int PB_MOSI = 2;
  localparam int PB_MISO = 3;
  localparam int PB_OC0 = 4;
  localparam int PB_TIMER1_COMPARE_A_OUT = 5;
  localparam int PB_TIMER1_COMPARE_B_OUT = 6;
  localparam int PB_OC2 = 7;
  // ----------------------------------------
  // port d pin positions
  // ----------------------------------------
  localparam int PD_SCL = 0;
  localparam int PD_SDA = 1;
  localparam int PD_RXD = 2;
  localparam int PD_TXD = 3;
  localparam int PD_XCK = 5;
  localparam int PD_T1 = 6;
  localparam int PD_T2 = 7;
  // ----------------------------------------
  // port c: mask setting must be below this for pin i
  // ----------------------------------------
  localparam logic [7:0][2:0] PC_MASK_LIMIT = {3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7};
  localparam logic [2:0] MASK_LEGACY = 3'h0;
  localparam logic RESET_LEGACY = 1'b1;
endpackage

// [verilog/paof_override.sv]
/*
  Port alternate-function override: combines port register bits with
  peripheral override enables/values for ports b, c and d.
  Assumes port registers, peripherals and pad drivers lie outside;
  all inputs synchronous to clk_in. Pin outputs come from flip-flops.
*/
`timescale 1ns/1ps
module paof_override (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic legacy_mode_clear_in,
  input wire logic legacy_mode_set_in,
  input wire logic global_pullup_disable_in,
  input wire logic [7:0] port_b_dir_in,
  input wire logic [7:0] port_b_out_in,
  input wire logic [7:0] port_b_pin_in,
  input wire logic serial_periph_enable_bit_in,
  input wire logic serial_master_select_in,
  input wire logic spi_master_out_in,
  input wire logic spi_slave_out_in,
  input wire logic spi_clock_out_in,
  input wire logic [3:0] compare_enable_in,
  input wire logic timer0_compare_out_in,
  input wire logic timer1_compare_a_out_in,
  input wire logic timer1_compare_b_out_in,
  input wire logic timer1_compare_c_out_in,
  input wire logic timer2_compare_out_in,
  input wire logic timer1_compare_c_sel_in,
  input wire logic [7:0] port_c_dir_in,
  input wire logic [7:0] port_c_out_in,
  input wire logic ext_mem_enable_in,
  input wire logic [2:0] ext_mem_addr_mask_in,
  input wire logic [7:0] ext_mem_addr_high_in,
  input wire logic [7:0] port_d_dir_in,
  input wire logic [7:0] port_d_out_in,
  input wire logic [7:0] port_d_pin_in,
  input wire logic usart1_sync_mode_in,
  input wire logic usart1_ext_clock_out_in,
  input wire logic usart1_tx_enable_in,
  input wire logic usart1_rx_enable_in,
  input wire logic usart1_transmit_pin_in,
  input wire logic twi_enable_in,
  input wire logic twi_sda_drive_low_in,
  input wire logic twi_scl_drive_low_in,
  output logic legacy_mode_out,
  output logic [7:0] port_b_oe_out,
  output logic [7:0] port_b_pad_out,
  output logic [7:0] port_b_pullup_out,
  output logic [7:0] port_c_oe_out,
  output logic [7:0] port_c_pad_out,
  output logic [7:0] port_c_pullup_out,
  output logic [7:0] port_d_oe_out,
  output logic [7:0] port_d_pad_out,
  output logic [7:0] port_d_pullup_out,
  output logic spi_master_in_out,
  output logic spi_slave_in_out,
  output logic spi_clock_in_out,
  output logic spi_slave_active_out,
  output logic timer1_count_input_out,
  output logic timer2_count_input_out,
  output logic usart1_ext_clock_in_out,
  output logic usart1_receive_pin_out,
  output logic twi_sda_in_out,
  output logic twi_scl_in_out
);
  // ----------------------------------------
  // override mixing
  // ----------------------------------------
  function automatic logic mix(input logic en, input logic ov, input logic base);
    mix = en ? ov : base;
  endfunction

  logic legacy_mode, next_legacy_mode;
  logic [7:0] b_oe, b_pad, b_pu, next_b_oe, next_b_pad, next_b_pu;
  logic [7:0] c_oe, c_pad, c_pu, next_c_oe, next_c_pad, next_c_pu;
  logic [7:0] d_oe, d_pad, d_pu, next_d_oe, next_d_pad, next_d_pu;
  logic [8:0] in_reg, next_in_reg;

  // ----------------------------------------
  // legacy compatibility mode
  // ----------------------------------------
  always_comb begin
    next_legacy_mode = legacy_mode;
    if (legacy_mode_set_in) begin
      next_legacy_mode = 1'b1;
    end else if (legacy_mode_clear_in) begin
      next_legacy_mode = 1'b0;
    end
  end

  // ----------------------------------------
  // port b: spi and compare outputs
  // ----------------------------------------
  logic spi_on, spi_master, spi_slave, pu_base_b;
  logic [7:0] pv_en, pv_val;
  always_comb begin
    spi_on = serial_periph_enable_bit_in;
    spi_master = spi_on & serial_master_select_in;
    spi_slave = spi_on & ~serial_master_select_in;
    next_b_oe = port_b_dir_in;
    next_b_pu = port_b_out_in & ~port_b_dir_in & {8{~global_pullup_disable_in}};
    pv_en = {compare_enable_in[3], compare_enable_in[2], compare_enable_in[1],
             compare_enable_in[0], 4'h0};
    pv_val = 8'h00;
    pv_val[paof_pkg::PB_OC0] = timer0_compare_out_in;
    pv_val[paof_pkg::PB_TIMER1_COMPARE_A_OUT] = timer1_compare_a_out_in;
    pv_val[paof_pkg::PB_TIMER1_COMPARE_B_OUT] = timer1_compare_b_out_in;
    // legacy mode: no compare c, pin belongs to timer2
    pv_val[paof_pkg::PB_OC2] = (timer1_compare_c_sel_in & ~legacy_mode) ?
                     timer1_compare_c_out_in : timer2_compare_out_in;
    // slave forces mosi, clock, select in; master forces miso in
    next_b_oe[paof_pkg::PB_MOSI] = mix(spi_slave, 1'b0,
                                       port_b_dir_in[paof_pkg::PB_MOSI]);
    next_b_oe[paof_pkg::PB_SCK] = mix(spi_slave, 1'b0,
                                      port_b_dir_in[paof_pkg::PB_SCK]);
    next_b_oe[paof_pkg::PB_SEL] = mix(spi_slave, 1'b0,
                                      port_b_dir_in[paof_pkg::PB_SEL]);
    next_b_oe[paof_pkg::PB_MISO] = mix(spi_master, 1'b0,
                                       port_b_dir_in[paof_pkg::PB_MISO]);
    for (int i = 0; i < 4; i++) begin
      pu_base_b = port_b_out_in[i] & ~global_pullup_disable_in;
      // forced input: pull-up from port bit and global disable
      if ((i == paof_pkg::PB_MISO) ? spi_master : spi_slave) begin
        next_b_pu[i] = pu_base_b;
      end
    end
    // spi outputs replace pin value, select pin never
    pv_en[paof_pkg::PB_MOSI] = spi_master;
    pv_val[paof_pkg::PB_MOSI] = spi_master_out_in;
    pv_en[paof_pkg::PB_SCK] = spi_master;
    pv_val[paof_pkg::PB_SCK] = spi_clock_out_in;
    pv_en[paof_pkg::PB_MISO] = spi_slave;
    pv_val[paof_pkg::PB_MISO] = spi_slave_out_in;
    for (int i = 0; i < 8; i++) begin
      // direction untouched on compare pins; value only
      next_b_pad[i] = mix(pv_en[i], pv_val[i], port_b_out_in[i]);
    end
  end

  // ----------------------------------------
  // port c: high address byte
  // ----------------------------------------
  logic [2:0] mask_eff;
  logic addr_en;
  always_comb begin
    mask_eff = legacy_mode ? paof_pkg::MASK_LEGACY : ext_mem_addr_mask_in;
    for (int i = 0; i < 8; i++) begin
      addr_en = ext_mem_enable_in & (mask_eff < paof_pkg::PC_MASK_LIMIT[i]);
      next_c_oe[i] = legacy_mode | mix(addr_en, 1'b1, port_c_dir_in[i]);
      next_c_pu[i] = mix(addr_en, 1'b0,
                         port_c_out_in[i] & ~next_c_oe[i] & ~global_pullup_disable_in);
      next_c_pad[i] = mix(addr_en, ext_mem_addr_high_in[i], port_c_out_in[i]);
    end
  end

  // ----------------------------------------
  // port d: usart1, two-wire, timer inputs
  // ----------------------------------------
  logic xck_on, tx_on, rx_on, tw_on;
  always_comb begin
    xck_on = usart1_sync_mode_in & ~legacy_mode;
    tx_on = usart1_tx_enable_in & ~legacy_mode;
    rx_on = usart1_rx_enable_in & ~legacy_mode;
    tw_on = twi_enable_in & ~legacy_mode;
    next_d_oe = port_d_dir_in;
    next_d_pad = port_d_out_in;
    next_d_pu = port_d_out_in & ~port_d_dir_in & {8{~global_pullup_disable_in}};
    // clock pin direction stays with its direction bit
    next_d_pad[paof_pkg::PD_XCK] = mix(xck_on, usart1_ext_clock_out_in,
                                       port_d_out_in[paof_pkg::PD_XCK]);
    next_d_oe[paof_pkg::PD_TXD] = mix(tx_on, 1'b1, port_d_dir_in[paof_pkg::PD_TXD]);
    next_d_pu[paof_pkg::PD_TXD] = mix(tx_on, 1'b0, next_d_pu[paof_pkg::PD_TXD]);
    next_d_pad[paof_pkg::PD_TXD] = mix(tx_on, usart1_transmit_pin_in,
                                       port_d_out_in[paof_pkg::PD_TXD]);
    next_d_oe[paof_pkg::PD_RXD] = mix(rx_on, 1'b0, port_d_dir_in[paof_pkg::PD_RXD]);
    next_d_pu[paof_pkg::PD_RXD] = mix(rx_on,
      port_d_out_in[paof_pkg::PD_RXD] & ~global_pullup_disable_in,
      next_d_pu[paof_pkg::PD_RXD]);
    // two-wire: open drain, pad value held low
    next_d_oe[paof_pkg::PD_SDA] = mix(tw_on, twi_sda_drive_low_in,
                                      port_d_dir_in[paof_pkg::PD_SDA]);
    next_d_pad[paof_pkg::PD_SDA] = mix(tw_on, 1'b0, port_d_out_in[paof_pkg::PD_SDA]);
    next_d_pu[paof_pkg::PD_SDA] = mix(tw_on,
      port_d_out_in[paof_pkg::PD_SDA] & ~global_pullup_disable_in,
      next_d_pu[paof_pkg::PD_SDA]);
    next_d_oe[paof_pkg::PD_SCL] = mix(tw_on, twi_scl_drive_low_in,
                                      port_d_dir_in[paof_pkg::PD_SCL]);
    next_d_pad[paof_pkg::PD_SCL] = mix(tw_on, 1'b0, port_d_out_in[paof_pkg::PD_SCL]);
    next_d_pu[paof_pkg::PD_SCL] = mix(tw_on,
      port_d_out_in[paof_pkg::PD_SCL] & ~global_pullup_disable_in,
      next_d_pu[paof_pkg::PD_SCL]);
  end

  // ----------------------------------------
  // peripheral inputs from pins
  // ----------------------------------------
  always_comb begin
    next_in_reg[0] = port_b_pin_in[paof_pkg::PB_MISO];
    next_in_reg[1] = port_b_pin_in[paof_pkg::PB_MOSI];
    next_in_reg[2] = port_b_pin_in[paof_pkg::PB_SCK];
    next_in_reg[3] = spi_slave & ~port_b_pin_in[paof_pkg::PB_SEL];
    next_in_reg[4] = port_d_pin_in[paof_pkg::PD_T1];
    next_in_reg[5] = port_d_pin_in[paof_pkg::PD_T2];
    next_in_reg[6] = xck_on & ~port_d_dir_in[paof_pkg::PD_XCK] &
                     port_d_pin_in[paof_pkg::PD_XCK];
    next_in_reg[7] = rx_on ? port_d_pin_in[paof_pkg::PD_RXD] : 1'b1;
    next_in_reg[8] = tw_on ? port_d_pin_in[paof_pkg::PD_SDA] & port_d_pin_in[paof_pkg::PD_SCL]
                           : 1'b1;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      legacy_mode <= paof_pkg::RESET_LEGACY;
      b_oe <= 8'h00;
      b_pad <= 8'h00;
      b_pu <= 8'h00;
      c_oe <= 8'hff;
      c_pad <= 8'h00;
      c_pu <= 8'h00;
      d_oe <= 8'h00;
      d_pad <= 8'h00;
      d_pu <= 8'h00;
      in_reg <= 9'h180;
    end else begin
      legacy_mode <= next_legacy_mode;
      b_oe <= next_b_oe;
      b_pad <= next_b_pad;
      b_pu <= next_b_pu;
      c_oe <= next_c_oe;
      c_pad <= next_c_pad;
      c_pu <= next_c_pu;
      d_oe <= next_d_oe;
      d_pad <= next_d_pad;
      d_pu <= next_d_pu;
      in_reg <= next_in_reg;
    end
  end

  assign legacy_mode_out = legacy_mode;
  assign port_b_oe_out = b_oe;
  assign port_b_pad_out = b_pad;
  assign port_b_pullup_out = b_pu;
  assign port_c_oe_out = c_oe;
  assign port_c_pad_out = c_pad;
  assign port_c_pullup_out = c_pu;
  assign port_d_oe_out = d_oe;
  assign port_d_pad_out = d_pad;
  assign port_d_pullup_out = d_pu;
  assign spi_master_in_out = in_reg[0];
  assign spi_slave_in_out = in_reg[1];
  assign spi_clock_in_out = in_reg[2];
  assign spi_slave_active_out = in_reg[3];
  assign timer1_count_input_out = in_reg[4];
  assign timer2_count_input_out = in_reg[5];
  assign usart1_ext_clock_in_out = in_reg[6];
  assign usart1_receive_pin_out = in_reg[7];
  assign twi_sda_in_out = in_reg[8];
  assign twi_scl_in_out = in_reg[8];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence slave_on_s;
    serial_periph_enable_bit_in && !serial_master_select_in;
  endsequence

  sequence master_on_s;
    serial_periph_enable_bit_in && serial_master_select_in;
  endsequence

  chk_slave_mosi_in: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    slave_on_s |=> !port_b_oe_out[2]) else $error("mosi driven in slave role");
  chk_slave_sck_in: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    slave_on_s |=> !port_b_oe_out[1] && !port_b_oe_out[0])
    else $error("clock or select driven in slave role");
  chk_master_dir_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    serial_periph_enable_bit_in && serial_master_select_in |=>
    port_b_oe_out[2:0] == $past(port_b_dir_in[2:0]) && !port_b_oe_out[3])
    else $error("master role pin directions wrong");
  chk_forced_pullup: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    slave_on_s |=> port_b_pullup_out[2] ==
    ($past(port_b_out_in[2]) && !$past(global_pullup_disable_in)))
    else $error("forced input pull-up wrong");
  chk_select_active: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    slave_on_s ##0 port_b_pin_in[0] |=> !spi_slave_active_out)
    else $error("slave active while select high");
  chk_slave_miso_dir: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    slave_on_s |=> port_b_oe_out[3] == $past(port_b_dir_in[3]) &&
    port_b_pad_out[3] == $past(spi_slave_out_in))
    else $error("miso direction or value wrong in slave role");
  chk_master_values: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    master_on_s |=> port_b_pad_out[2] == $past(spi_master_out_in) &&
    port_b_pad_out[1] == $past(spi_clock_out_in) &&
    port_b_pad_out[0] == $past(port_b_out_in[0]))
    else $error("master role pin values wrong");
  chk_compare_value: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    compare_enable_in[0] |=> port_b_pad_out[4] == $past(timer0_compare_out_in) &&
    port_b_oe_out[4] == $past(port_b_dir_in[4]))
    else $error("compare value override wrong");
  chk_legacy_portc_out: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    legacy_mode |=> port_c_oe_out == 8'hff) else $error("port c input in legacy mode");
  chk_legacy_set_wins: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    legacy_mode_set_in |=> legacy_mode_out) else $error("legacy mode set lost");
  chk_addr_top_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ext_mem_enable_in && (legacy_mode || ext_mem_addr_mask_in == 3'h0) |=>
    port_c_pad_out == $past(ext_mem_addr_high_in) && port_c_pullup_out == 8'h00)
    else $error("address byte not driven");
  chk_addr_mask_six: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ext_mem_enable_in && !legacy_mode && ext_mem_addr_mask_in == 3'h6 |=>
    port_c_pad_out[1:0] == $past(ext_mem_addr_high_in[1:0]) &&
    port_c_pad_out[7:2] == $past(port_c_out_in[7:2]))
    else $error("mask six selection wrong");
  chk_count_inputs: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> timer1_count_input_out == $past(port_d_pin_in[6]) &&
    timer2_count_input_out == $past(port_d_pin_in[7]) &&
    port_d_oe_out[7:6] == $past(port_d_dir_in[7:6]))
    else $error("timer count pins overridden");
  chk_legacy_no_xck: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    legacy_mode |=> port_d_pad_out[5] == $past(port_d_out_in[5]))
    else $error("usart clock active in legacy mode");
  chk_legacy_inputs_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    legacy_mode |=> usart1_receive_pin_out && twi_sda_in_out && twi_scl_in_out &&
    !usart1_ext_clock_in_out) else $error("usart1 or two-wire input live in legacy mode");
  chk_txd_forced_out: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    usart1_tx_enable_in && !legacy_mode |=> port_d_oe_out[3] &&
    port_d_pad_out[3] == $past(usart1_transmit_pin_in))
    else $error("usart1 transmit pin not driven");
endmodule

// [test/paof_far_side.sv]
/*
  Far-side pin model: external spi device, two-wire bus and clock sources.
  Assumes the block's registered oe/pad/pull-up outputs as pad controls.
*/
`timescale 1ns/1ps
module paof_far_side (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] drive_en_in,
  input wire logic [7:0] drive_val_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pullup_in,
  output logic [7:0] pin_out
);
  // ----------------------------------------
  // floating level, changes every cycle
  // ----------------------------------------
  logic flip;
  logic next_flip;
  always_comb begin
    next_flip = ~flip;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flip <= 1'b0;
    end else begin
      flip <= next_flip;
    end
  end
  // ----------------------------------------
  // wire level per pin
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_in[i]) begin
        pin_out[i] = pad_in[i];
      end else if (drive_en_in[i]) begin
        pin_out[i] = drive_val_in[i];
      end else if (pullup_in[i]) begin
        pin_out[i] = 1'b1;
      end else begin
        pin_out[i] = flip;
      end
    end
  end
endmodule

// [test/paof_override_tb.sv]
/*
  Self-checking bench for the override block.
  Assumes far-side models on ports b and d; inputs change at falling edges.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module paof_override_tb;
  logic clk_in, rst_n_in, legacy_mode_clear_in, legacy_mode_set_in, global_pullup_disable_in;
  logic [7:0] port_b_dir_in, port_b_out_in, port_b_pin_in, port_c_dir_in, port_c_out_in;
  logic [7:0] ext_mem_addr_high_in, port_d_dir_in, port_d_out_in, port_d_pin_in;
  logic serial_periph_enable_bit_in, serial_master_select_in, spi_master_out_in, spi_slave_out_in;
  logic spi_clock_out_in, timer0_compare_out_in, timer1_compare_a_out_in, timer1_compare_b_out_in;
  logic timer1_compare_c_out_in, timer2_compare_out_in, timer1_compare_c_sel_in, ext_mem_enable_in;
  logic [3:0] compare_enable_in;
  logic [2:0] ext_mem_addr_mask_in;
  logic usart1_sync_mode_in, usart1_ext_clock_out_in, usart1_tx_enable_in, usart1_rx_enable_in;
  logic usart1_transmit_pin_in, twi_enable_in, twi_sda_drive_low_in, twi_scl_drive_low_in;
  logic legacy_mode_out, spi_master_in_out, spi_slave_in_out, spi_clock_in_out;
  logic spi_slave_active_out, timer1_count_input_out, timer2_count_input_out;
  logic usart1_ext_clock_in_out, usart1_receive_pin_out, twi_sda_in_out, twi_scl_in_out;
  logic [7:0] port_b_oe_out, port_b_pad_out, port_b_pullup_out, port_c_oe_out, port_c_pad_out;
  logic [7:0] port_c_pullup_out, port_d_oe_out, port_d_pad_out, port_d_pullup_out;
  logic [7:0] ext_b_val, ext_d_val, en;
  int err_total, check_count;
  paof_override u_paof_override (.*);
  paof_far_side u_paof_far_side (.clk_in(clk_in), .rst_n_in(rst_n_in), .drive_en_in(8'h0f),
    .drive_val_in(ext_b_val), .oe_in(port_b_oe_out), .pad_in(port_b_pad_out),
    .pullup_in(port_b_pullup_out), .pin_out(port_b_pin_in));
  paof_far_side u_paof_far_side_d (.clk_in(clk_in), .rst_n_in(rst_n_in), .drive_en_in(8'hff),
    .drive_val_in(ext_d_val), .oe_in(port_d_oe_out), .pad_in(port_d_pad_out),
    .pullup_in(port_d_pullup_out), .pin_out(port_d_pin_in));
  // ----------------------------------------
  // clock, access and closing tasks
  // ----------------------------------------
  always #25 clk_in = ~clk_in;
  // one edge to register, one for pin feedback, one spare
  task automatic settle;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic end_of_test;
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    err_total++;
    end_of_test;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {legacy_mode_clear_in, legacy_mode_set_in, global_pullup_disable_in, port_b_dir_in,
     port_b_out_in, port_c_dir_in, port_c_out_in, ext_mem_addr_high_in, port_d_dir_in,
     port_d_out_in, serial_periph_enable_bit_in, serial_master_select_in, spi_master_out_in,
     spi_slave_out_in, spi_clock_out_in, timer0_compare_out_in, timer1_compare_a_out_in,
     timer1_compare_b_out_in, timer1_compare_c_out_in, timer2_compare_out_in,
     timer1_compare_c_sel_in, ext_mem_enable_in, compare_enable_in, ext_mem_addr_mask_in,
     usart1_sync_mode_in, usart1_ext_clock_out_in, usart1_tx_enable_in, usart1_rx_enable_in,
     usart1_transmit_pin_in, twi_enable_in, twi_sda_drive_low_in, twi_scl_drive_low_in,
     clk_in, rst_n_in, ext_b_val, ext_d_val} = '0;
    err_total = 0;
    check_count = 0;
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'b1;
    // legacy mode after reset
    {ext_mem_enable_in, ext_mem_addr_mask_in, ext_mem_addr_high_in} = {1'b1, 3'h7, 8'ha5};
    {port_b_dir_in, compare_enable_in, timer1_compare_c_sel_in} = {8'h80, 4'h8, 1'b1};
    {timer1_compare_c_out_in, usart1_sync_mode_in, usart1_ext_clock_out_in} = 3'h7;
    {usart1_rx_enable_in, twi_enable_in} = 2'h3;
    settle;
    `CHK("legacy", 1'b1, legacy_mode_out)
    `CHK("c_oe", 8'hff, port_c_oe_out)
    `CHK("c_pad", 8'ha5, port_c_pad_out)
    `CHK("b_pad7", 1'b0, port_b_pad_out[7])
    `CHK("rxd", 1'b1, usart1_receive_pin_out)
    `CHK("sda", 1'b1, twi_sda_in_out)
    `CHK("d_pad5", 1'b0, port_d_pad_out[5])
    legacy_mode_clear_in = 1'b1;
    settle;
    legacy_mode_clear_in = 1'b0;
    `CHK("legacy", 1'b0, legacy_mode_out)
    `CHK("b_pad7", 1'b1, port_b_pad_out[7])
    `CHK("d_pad5", 1'b1, port_d_pad_out[5])
    `CHK("rxd", 1'b0, usart1_receive_pin_out)
    // address mask sweep, index 8 means memory off
    {port_c_dir_in, port_c_out_in, ext_mem_addr_high_in} = {8'h01, 8'hff, 8'h3c};
    for (int k = 0; k < 9; k++) begin
      ext_mem_enable_in = (k < 8);
      ext_mem_addr_mask_in = k[2:0];
      settle;
      for (int i = 0; i < 8; i++) begin
        en[i] = (k < 8) && (ext_mem_addr_mask_in < paof_pkg::PC_MASK_LIMIT[i]);
      end
      `CHK("c_oe", en | 8'h01, port_c_oe_out)
      `CHK("c_pad", (8'h3c & en) | ~en, port_c_pad_out)
      `CHK("c_pu", ~en & 8'hfe, port_c_pullup_out)
    end
    // spi slave role
    {port_b_out_in, port_b_dir_in, serial_periph_enable_bit_in} = {8'h0f, 8'h8f, 1'b1};
    {spi_slave_out_in, ext_b_val} = {1'b1, 8'h06};
    settle;
    `CHK("b_oe", 4'h8, port_b_oe_out[3:0])
    `CHK("b_pu", 3'h7, port_b_pullup_out[2:0])
    `CHK("miso", 1'b1, port_b_pad_out[3])
    `CHK("slv_in", 1'b1, spi_slave_in_out)
    `CHK("sck_in", 1'b1, spi_clock_in_out)
    `CHK("slv_act", 1'b1, spi_slave_active_out)
    {ext_b_val, global_pullup_disable_in} = {8'h01, 1'b1};
    settle;
    `CHK("slv_act", 1'b0, spi_slave_active_out)
    `CHK("slv_in", 1'b0, spi_slave_in_out)
    `CHK("sck_in", 1'b0, spi_clock_in_out)
    `CHK("b_pu", 3'h0, port_b_pullup_out[2:0])
    // spi master role
    {serial_master_select_in, port_b_dir_in, ext_b_val} = {1'b1, 8'h85, 8'h08};
    {global_pullup_disable_in, spi_master_out_in, spi_clock_out_in} = 3'h0;
    settle;
    `CHK("b_oe", 4'h5, port_b_oe_out[3:0])
    `CHK("b_pad", 3'h1, port_b_pad_out[2:0])
    `CHK("b_pu3", 1'b1, port_b_pullup_out[3])
    `CHK("mst_in", 1'b1, spi_master_in_out)
    // compare outputs, direction set by software in the same step as the enables
    {serial_periph_enable_bit_in, port_b_dir_in, compare_enable_in} = {1'b0, 8'hf0, 4'hf};
    {timer0_compare_out_in, timer1_compare_a_out_in, timer1_compare_b_out_in} = 3'h5;
    {timer1_compare_c_out_in, timer2_compare_out_in} = 2'h0;
    settle;
    `CHK("b_pad", 4'h5, port_b_pad_out[7:4])
    `CHK("b_oe", 4'hf, port_b_oe_out[7:4])
    {timer1_compare_c_sel_in, timer2_compare_out_in} = 2'h1;
    settle;
    `CHK("b_pad7", 1'b1, port_b_pad_out[7])
    compare_enable_in = 4'h0;
    settle;
    `CHK("b_pad", 4'h0, port_b_pad_out[7:4])
    // port d timer inputs, usart1 clock and transmit pin, two-wire
    {ext_d_val, port_d_dir_in, port_d_out_in} = {8'h80, 8'h30, 8'hc0};
    usart1_sync_mode_in = 1'b1;
    settle;
    `CHK("t2_cnt", 1'b1, timer2_count_input_out)
    `CHK("t1_cnt", 1'b0, timer1_count_input_out)
    `CHK("d_oe", 2'h0, port_d_oe_out[7:6])
    `CHK("d_pu", 2'h3, port_d_pullup_out[7:6])
    `CHK("d_pad5", 1'b1, port_d_pad_out[5])
    `CHK("d_oe5", 1'b1, port_d_oe_out[5])
    {port_d_dir_in, ext_d_val} = {8'h00, 8'ha0};
    settle;
    `CHK("xck_in", 1'b1, usart1_ext_clock_in_out)
    `CHK("d_oe5", 1'b0, port_d_oe_out[5])
    usart1_sync_mode_in = 1'b0;
    settle;
    `CHK("xck_in", 1'b0, usart1_ext_clock_in_out)
    `CHK("d_pad5", 1'b0, port_d_pad_out[5])
    {twi_sda_drive_low_in, usart1_tx_enable_in, usart1_transmit_pin_in} = 3'h7;
    settle;
    `CHK("d_oe", 4'ha, port_d_oe_out[3:0])
    `CHK("d_pad3", 1'b1, port_d_pad_out[3])
    {twi_sda_drive_low_in, ext_d_val} = {1'b0, 8'h03};
    settle;
    `CHK("sda_in", 1'b1, twi_sda_in_out)
    `CHK("scl_in", 1'b1, twi_scl_in_out)
    twi_scl_drive_low_in = 1'b1;
    settle;
    `CHK("d_oe", 2'h1, port_d_oe_out[1:0])
    `CHK("scl_in", 1'b0, twi_scl_in_out)
    // set beats clear; legacy again shuts usart1 and two-wire out
    {legacy_mode_set_in, legacy_mode_clear_in} = 2'h3;
    settle;
    legacy_mode_set_in = 1'b0;
    `CHK("legacy", 1'b1, legacy_mode_out)
    `CHK("d_oe", 4'h0, port_d_oe_out[3:0])
    `CHK("scl_in", 1'b1, twi_scl_in_out)
    `CHK("c_oe", 8'hff, port_c_oe_out)
    settle;
    legacy_mode_clear_in = 1'b0;
    `CHK("legacy", 1'b0, legacy_mode_out)
    // reset in mid-run restores legacy mode
    rst_n_in = 1'b0;
    settle;
    `CHK("c_oe", 8'hff, port_c_oe_out)
    rst_n_in = 1'b1;
    settle;
    `CHK("legacy", 1'b1, legacy_mode_out)
    end_of_test;
  end
endmodule
